// ===== design/smh_port.v
// Transmit side of a two port serial link with modem line handshake
//
// How it works
// - CD option: ignore, or send only CD off
// - DR option: ignore, or send only DR on
// - RS option: always on, or on before sending
// - Characters start only while CS is on
// - Each line option selected by software independently
// - Two ports, each up to 115200 bit/s
// - Thirteen standard bit rates from 300 upward
`timescale 1ns/1ns
`default_nettype none
`include "smh_consts.vh"

module smh_port #(
    parameter NPORT  = `SMH_NPORT,
    parameter DW     = `SMH_DATA_W,
    parameter DEPTH  = `SMH_FIFO_DEPTH,
    parameter AW     = 2
) (
    // Clock and reset
    input  wire                core_clk,
    input  wire                resetn,
    // Character stream in, one lane per port
    input  wire [NPORT*DW-1:0] tx_data,
    input  wire [NPORT-1:0]    tx_valid,
    output wire [NPORT-1:0]    tx_ready,
    // Frame format per port
    input  wire [NPORT*4-1:0]  baud_sel,
    input  wire [NPORT-1:0]    char7,
    input  wire [NPORT-1:0]    stop2,
    input  wire [NPORT-1:0]    parity_en,
    input  wire [NPORT-1:0]    parity_odd,
    // Control line options per port, 0 selects setting 1
    input  wire [NPORT-1:0]    cd_check_mode,
    input  wire [NPORT-1:0]    dr_check_mode,
    input  wire [NPORT-1:0]    rs_mode,
    input  wire [NPORT-1:0]    er_mode,
    input  wire [NPORT-1:0]    er_sw,
    // Modem lines, high means on
    input  wire [NPORT-1:0]    cd_in,
    input  wire [NPORT-1:0]    dr_in,
    input  wire [NPORT-1:0]    cs_in,
    output wire [NPORT-1:0]    sd_out,
    output wire [NPORT-1:0]    rs_out,
    output wire [NPORT-1:0]    er_out,
    // Status per port
    output wire [NPORT-1:0]    tx_busy,
    output wire [NPORT-1:0]    tx_blocked
);

    // One-hot transmitter states
    localparam [4:0] ST_IDLE  = 5'b0_0001;  // Nothing to send
    localparam [4:0] ST_LEAD  = 5'b0_0010;  // RS raised, lead time running
    localparam [4:0] ST_GATE  = 5'b0_0100;  // Waiting for line permission
    localparam [4:0] ST_SHIFT = 5'b0_1000;  // Frame bits on the wire
    localparam [4:0] ST_DONE  = 5'b1_0000;  // Frame ended, choose next step

    // Lead count is worked out in integer arithmetic, then cut to the counter width
    localparam integer LEAD_INT = `SMH_RS_LEAD_CYC;
    localparam [15:0]  LEAD_CYC = LEAD_INT[15:0];

    // Bit period in core clocks for a rate code, rounded to nearest
    // Sixteen bits hold the slowest rate's 33333 clocks with room to spare
    function [15:0] smh_div;
        input [3:0] sel;
        integer     rate;
        integer     q;
        begin
            rate = 115200;
            case (sel)
                `SMH_BR_300:    rate = 300;
                `SMH_BR_600:    rate = 600;
                `SMH_BR_1200:   rate = 1200;
                `SMH_BR_2400:   rate = 2400;
                `SMH_BR_4800:   rate = 4800;
                `SMH_BR_9600:   rate = 9600;
                `SMH_BR_14400:  rate = 14400;
                `SMH_BR_19200:  rate = 19200;
                `SMH_BR_28800:  rate = 28800;
                `SMH_BR_38400:  rate = 38400;
                `SMH_BR_57600:  rate = 57600;
                `SMH_BR_76800:  rate = 76800;
                default:        rate = 115200;  // Fastest rate caps codes above
            endcase
            q       = (`SMH_CLK_HZ + rate / 2) / rate;
            smh_div = q[15:0];
        end
    endfunction

    // Frame length in bits: start, data, parity, stop
    // Longest frame, 8 data, parity and 2 stops, is 12 bits
    function [3:0] smh_len;
        input c7;
        input pe;
        input s2;
        begin
            smh_len = 4'h1 + (c7 ? 4'h7 : 4'h8) + {3'b000, pe} + (s2 ? 4'h2 : 4'h1);
        end
    endfunction

    // Each port is a full copy of the logic below, so the ports share
    // nothing but the clock and reset and never hold each other up
    genvar p;
    generate
        for (p = 0; p < NPORT; p = p + 1) begin : g_port
            // Two flop synchronisers for the modem inputs
            reg  [2:0]    sync_a;          // First stage, read only by sync_b
            reg  [2:0]    sync_b;          // Second stage: {cs, dr, cd}
            wire          cd_on;
            wire          dr_on;
            wire          cs_on;
            wire          allowed;
            // FIFO drain side
            wire          fifo_valid;
            wire [DW-1:0] fifo_data;
            reg           fifo_pop;
            // Transmitter state
            reg  [4:0]    state;
            reg  [15:0]   bit_cnt;         // Clocks left in current bit
            reg  [15:0]   lead_cnt;        // Clocks left of RS lead time
            reg  [3:0]    bits_left;       // Bits left in frame
            reg  [`SMH_FRAME_W-1:0] shreg; // Frame, LSB leaves first
            reg  [`SMH_FRAME_W-1:0] next_frame;
            reg           par_bit;
            // Output flops
            reg           sd;
            reg           rs;
            reg           er;
            reg           busy;
            reg           blocked;

            assign cd_on = sync_b[0];
            assign dr_on = sync_b[1];
            assign cs_on = sync_b[2];

            // Line permission from CS and the selected CD and DR checks
            // Lines are judged after synchronising, so a change counts two clocks late
            assign allowed = cs_on
                           & (~cd_check_mode[p] | ~cd_on)
                           & (~dr_check_mode[p] | dr_on);

            // Pin inputs come from another party, so two flops first
            always @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    sync_a <= 3'b000;
                    sync_b <= 3'b000;
                end else begin
                    sync_a <= {cs_in[p], dr_in[p], cd_in[p]};
                    sync_b <= sync_a;
                end
            end

            // Four word buffer; ready stalls the character source
            smh_fifo #(
                .WIDTH (DW),
                .DEPTH (DEPTH),
                .AW    (AW)
            ) u_fifo (
                .core_clk  (core_clk),
                .resetn    (resetn),
                .in_valid  (tx_valid[p]),
                .in_ready  (tx_ready[p]),
                .in_data   (tx_data[p*DW +: DW]),
                .out_valid (fifo_valid),
                .out_ready (fifo_pop),
                .out_data  (fifo_data)
            );

            // Build the frame for the word at the FIFO head
            always @* begin
                if (char7[p]) begin
                    par_bit = (^fifo_data[6:0]) ^ parity_odd[p];
                    if (parity_en[p]) begin
                        next_frame = {3'b111, par_bit, fifo_data[6:0], 1'b0};
                    end else begin
                        next_frame = {4'b1111, fifo_data[6:0], 1'b0};
                    end
                end else begin
                    par_bit = (^fifo_data[7:0]) ^ parity_odd[p];
                    if (parity_en[p]) begin
                        next_frame = {2'b11, par_bit, fifo_data[7:0], 1'b0};
                    end else begin
                        next_frame = {3'b111, fifo_data[7:0], 1'b0};
                    end
                end
            end

            // Pop the FIFO in the cycle the frame is loaded
            // The pop and the frame load share one condition so no word is lost
            always @* begin
                fifo_pop = 1'b0;
                if ((state == ST_GATE) && fifo_valid && allowed) begin
                    fifo_pop = 1'b1;
                end
            end

            // Transmit sequencer; permission is judged once per character
            always @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    state     <= ST_IDLE;
                    bit_cnt   <= 16'h0000;
                    lead_cnt  <= 16'h0000;
                    bits_left <= 4'h0;
                    shreg     <= {`SMH_FRAME_W{1'b1}};
                    sd        <= `SMH_SD_RESET;
                    rs        <= `SMH_LINE_OFF;
                    busy      <= 1'b0;
                    blocked   <= 1'b0;
                end else begin
                    blocked <= 1'b0;
                    case (state)
                        ST_IDLE: begin
                            // Line rests at mark while nothing is queued
                            sd   <= 1'b1;
                            busy <= 1'b0;
                            rs   <= ~rs_mode[p];
                            if (fifo_valid) begin
                                busy <= 1'b1;
                                if (rs_mode[p]) begin
                                    // Raise RS and give the far end time to answer
                                    rs       <= 1'b1;
                                    lead_cnt <= LEAD_CYC;
                                    state    <= ST_LEAD;
                                end else begin
                                    state <= ST_GATE;
                                end
                            end
                        end
                        ST_LEAD: begin
                            // Lead time runs out regardless of CS; the gate judges CS after
                            if (lead_cnt <= 16'h0001) begin
                                state <= ST_GATE;
                            end else begin
                                lead_cnt <= lead_cnt - 1'b1;
                            end
                        end
                        ST_GATE: begin
                            if (!fifo_valid) begin
                                state <= ST_IDLE;
                            end else if (allowed) begin
                                shreg     <= next_frame >> 1;
                                sd        <= next_frame[0];
                                bits_left <= smh_len(char7[p], parity_en[p], stop2[p]);
                                bit_cnt   <= smh_div(baud_sel[p*4 +: 4]);
                                state     <= ST_SHIFT;
                            end else begin
                                // Held off by CS, CD or DR; word stays queued
                                blocked <= 1'b1;
                            end
                        end
                        ST_SHIFT: begin
                            // A CS drop mid frame does not cut it short; the far end
                            // would otherwise see a broken character
                            if (bit_cnt <= 16'h0001) begin
                                bit_cnt <= smh_div(baud_sel[p*4 +: 4]);
                                if (bits_left <= 4'h1) begin
                                    sd    <= 1'b1;
                                    state <= ST_DONE;
                                end else begin
                                    sd        <= shreg[0];
                                    shreg     <= {1'b1, shreg[`SMH_FRAME_W-1:1]};
                                    bits_left <= bits_left - 1'b1;
                                end
                            end else begin
                                bit_cnt <= bit_cnt - 1'b1;
                            end
                        end
                        ST_DONE: begin
                            // Back to back characters keep RS up
                            if (fifo_valid) begin
                                state <= ST_GATE;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                        default: begin
                            state <= ST_IDLE;
                        end
                    endcase
                end
            end

            // ER: on from reset in setting 1, software level in setting 2
            // Held off during reset so the far end never sees ready too early
            always @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    er <= `SMH_LINE_OFF;
                end else begin
                    er <= er_mode[p] ? er_sw[p] : 1'b1;
                end
            end

            assign sd_out[p]     = sd;
            assign rs_out[p]     = rs;
            assign er_out[p]     = er;
            assign tx_busy[p]    = busy;
            assign tx_blocked[p] = blocked;
        end
    endgenerate

endmodule // smh_port

`default_nettype wire

// ===== design/smh_consts.vh
// Constants for the serial port modem handshake block
`ifndef SMH_CONSTS_VH
`define SMH_CONSTS_VH

// Core clock
`define SMH_CLK_HZ        10000000
`define SMH_CLK_NS        100

// Number of serial ports and port width limits
`define SMH_NPORT         2
`define SMH_DATA_W        8
`define SMH_FIFO_DEPTH    4
`define SMH_FRAME_W       12

// Lead time of request-to-send before the first start bit (mode 2)
`define SMH_RS_LEAD_NS    100000
`define SMH_RS_LEAD_CYC   ((`SMH_RS_LEAD_NS + `SMH_CLK_NS - 1) / `SMH_CLK_NS)

// Bit rate select codes
`define SMH_BR_300        4'h0
`define SMH_BR_600        4'h1
`define SMH_BR_1200       4'h2
`define SMH_BR_2400       4'h3
`define SMH_BR_4800       4'h4
`define SMH_BR_9600       4'h5
`define SMH_BR_14400      4'h6
`define SMH_BR_19200      4'h7
`define SMH_BR_28800      4'h8
`define SMH_BR_38400      4'h9
`define SMH_BR_57600      4'hA
`define SMH_BR_76800      4'hB
`define SMH_BR_115200     4'hC

// Reset values of the line outputs (idle mark, lines off)
`define SMH_SD_RESET      1'b1
`define SMH_LINE_OFF      1'b0

`endif

// ===== design/smh_fifo.v
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none

module smh_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // Clock and reset
    input  wire             core_clk,
    input  wire             resetn,
    // Fill side
    input  wire             in_valid,
    output reg              in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output reg              out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];   // Storage words
    reg [AW-1:0]    wr_ptr;            // Next write slot
    reg [AW-1:0]    rd_ptr;            // Next read slot
    reg [AW:0]      count;             // Words held
    wire            do_wr;
    wire            do_rd;
    reg  [AW:0]     next_count;

    assign do_wr    = in_valid & in_ready;
    assign do_rd    = out_valid & out_ready;
    assign out_data = mem[rd_ptr];

    // Occupancy after this cycle
    always @* begin
        next_count = count;
        if (do_wr & ~do_rd) begin
            next_count = count + 1'b1;
        end else if (do_rd & ~do_wr) begin
            next_count = count - 1'b1;
        end
    end

    // Storage has no reset; only written words are ever read
    always @(posedge core_clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and registered full and empty flags
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            count     <= next_count;
            // Flags are registered so the top outputs come from flops
            in_ready  <= (next_count != DEPTH);
            out_valid <= (next_count != {(AW+1){1'b0}});
        end
    end

endmodule // smh_fifo

`default_nettype wire

// ===== tb/smh_port_checker.sv
// Assertion checker bound to the serial port modem handshake block
`timescale 1ns/1ns
`default_nettype none
module smh_port_checker #(
    parameter NPORT = 2
) (
    // Clock and reset
    input wire logic               core_clk,
    input wire logic               resetn,
    // Options
    input wire logic [NPORT*4-1:0] baud_sel,
    input wire logic [NPORT-1:0]   cd_check_mode,
    input wire logic [NPORT-1:0]   dr_check_mode,
    input wire logic [NPORT-1:0]   rs_mode,
    input wire logic [NPORT-1:0]   er_mode,
    input wire logic [NPORT-1:0]   er_sw,
    // Modem lines and status
    input wire logic [NPORT-1:0]   cd_in,
    input wire logic [NPORT-1:0]   dr_in,
    input wire logic [NPORT-1:0]   cs_in,
    input wire logic [NPORT-1:0]   sd_out,
    input wire logic [NPORT-1:0]   rs_out,
    input wire logic [NPORT-1:0]   er_out,
    input wire logic [NPORT-1:0]   tx_blocked
);
    logic        perm;   // Port 0 may send, judged on the raw lines
    logic [15:0] lo_cnt; // Cycles the port 0 line has been low
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    assign perm = cs_in[0] && !(cd_check_mode[0] && cd_in[0]) && !(dr_check_mode[0] && !dr_in[0]);
    // Low run counter; a mark sample clears it
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) lo_cnt <= 16'h0000;
        else if (sd_out[0]) lo_cnt <= 16'h0000;
        else lo_cnt <= lo_cnt + 16'h0001;
    end
    a_rs_steady: assert property ($past(resetn) |-> &(rs_out | rs_mode | $past(rs_mode)))
        else $error("request to send dropped in steady mode");
    a_er_follow: assert property ($past(resetn) |->
        er_out == (~$past(er_mode) | $past(er_sw)))
        else $error("terminal ready does not follow its option");
    a_rs_lead_gap: assert property (rs_mode[0] && $rose(rs_out[0]) |=> sd_out[0] [*8])
        else $error("start bit without lead after request to send");
    a_rs_off_idle: assert property (rs_mode[0] && !rs_out[0] |-> sd_out[0])
        else $error("line left idle with request to send off");
    a_cs_hold: assert property (!cs_in[0] [*4] ##0 tx_blocked[0] |=> sd_out[0] && tx_blocked[0])
        else $error("sent without clear to send");
    a_cd_hold: assert property ((cd_check_mode[0] && cd_in[0]) [*4] ##0 tx_blocked[0]
        |=> sd_out[0] && tx_blocked[0])
        else $error("sent while carrier on");
    a_dr_hold: assert property ((dr_check_mode[0] && !dr_in[0]) [*4] ##0 tx_blocked[0]
        |=> sd_out[0] && tx_blocked[0])
        else $error("sent while data set not ready");
    a_grant_sends: assert property (tx_blocked[0] ##1 perm [*3] |-> ##[1:4] !sd_out[0])
        else $error("no start bit after permission");
    a_bit_time: assert property (baud_sel[3:0] == 4'hc && $rose(sd_out[0]) |->
        lo_cnt % 87 == 0)
        else $error("bit time wrong at fastest rate");
endmodule // smh_port_checker
bind smh_port smh_port_checker #(.NPORT(NPORT)) i_smh_port_checker (
    .core_clk(core_clk), .resetn(resetn), .baud_sel(baud_sel),
    .cd_check_mode(cd_check_mode), .dr_check_mode(dr_check_mode), .rs_mode(rs_mode),
    .er_mode(er_mode), .er_sw(er_sw), .cd_in(cd_in), .dr_in(dr_in), .cs_in(cs_in),
    .sd_out(sd_out), .rs_out(rs_out), .er_out(er_out), .tx_blocked(tx_blocked));
`default_nettype wire

// ===== tb/smh_modem.sv
// Remote modem model: drives the control lines and receives frames
`timescale 1ns/1ns
`default_nettype none
module smh_modem (
    // Clock and bit length in clocks
    input  wire logic core_clk,
    input  wire logic [15:0] bit_cyc,
    // Lines to and from the block
    input  wire logic sd,
    output logic      cs,
    output logic      dr,
    output logic      cd,
    // Bench commands
    input  wire logic cs_cmd,
    input  wire logic dr_cmd,
    input  wire logic cd_cmd,
    // Received frame, stop bit on top
    output logic       rx_valid,
    output logic [8:0] rx_data
);
    // Remote grants sending by raising clear to send, and by dropping CD and raising DR when checked
    assign cs = cs_cmd;
    assign dr = dr_cmd;
    assign cd = cd_cmd;
    // Receiver, 8 data bits LSB first, sampled mid bit
    initial begin
        rx_valid = 1'b0;
        rx_data = 9'h000;
        forever begin
            @(negedge sd);
            repeat (bit_cyc / 2) @(posedge core_clk);
            for (int i = 0; i < 9; i++) begin
                repeat (bit_cyc) @(posedge core_clk);
                rx_data[i] <= sd;
            end
            rx_valid <= 1'b1;
            @(posedge core_clk);
            rx_valid <= 1'b0;
        end
    end
endmodule // smh_modem
`default_nettype wire

// ===== tb/test_serial_port_modem_handshake.sv
// Self-checking bench for the serial port modem handshake block
`timescale 1ns/1ns
`default_nettype none
module test_serial_port_modem_handshake;
    logic        core_clk;        // 10 MHz
    logic        resetn;
    int          miscompares = 0;
    int          compares = 0;
    logic [31:0] seed = 32'h0000_b1ed;
    logic [8:0]  exp_q[$];        // Frames expected at the modem
    logic [15:0] tx_data;
    logic [1:0]  tx_valid, cd_check_mode, dr_check_mode, rs_mode, er_mode, er_sw;
    logic        m_cs, m_dr, m_cd; // Modem line commands
    logic [7:0]  baud_sel;        // Rate codes, port 1 stays fastest
    logic [15:0] bit_cyc;         // Bit length the modem expects
    wire logic [1:0] tx_ready, sd_out, rs_out, er_out, tx_busy, tx_blocked;
    wire logic   cs0, dr0, cd0, rx_valid;
    wire logic [8:0] rx_data;
    // Port 1 lines stay granted; its ER options are still exercised
    smh_port i_smh_port (.core_clk(core_clk), .resetn(resetn), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .baud_sel(baud_sel), .char7(2'h0),
        .stop2(2'h0), .parity_en(2'h0), .parity_odd(2'h0), .cd_check_mode(cd_check_mode),
        .dr_check_mode(dr_check_mode), .rs_mode(rs_mode), .er_mode(er_mode), .er_sw(er_sw),
        .cd_in({1'b0, cd0}), .dr_in({1'b1, dr0}), .cs_in({1'b1, cs0}), .sd_out(sd_out),
        .rs_out(rs_out), .er_out(er_out), .tx_busy(tx_busy), .tx_blocked(tx_blocked));
    smh_modem i_smh_modem (.core_clk(core_clk), .bit_cyc(bit_cyc), .sd(sd_out[0]), .cs(cs0),
        .dr(dr0), .cd(cd0), .cs_cmd(m_cs), .dr_cmd(m_dr), .cd_cmd(m_cd), .rx_valid(rx_valid),
        .rx_data(rx_data));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task stall();
        miscompares++;
        $display("MISMATCH %0t wait ran out", $time);
        wrap_up();
    endtask
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Sample settled outputs mid cycle, return on the next rising edge
    task chk(input logic [1:0] got, input logic [1:0] exp);
        @(negedge core_clk);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %b exp %b", $time, got, exp);
        end
        @(posedge core_clk);
    endtask
    // Offer one character, held until the buffer takes it
    task send(input logic [7:0] d);
        int n;
        n = 0;
        tx_data[7:0] <= d;
        tx_valid[0] <= 1'b1;
        @(negedge core_clk);
        while (tx_ready[0] !== 1'b1 && n < 30000) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 30000) stall();
        @(posedge core_clk);
        exp_q.push_back({1'b1, d});
    endtask
    // Wait until every queued frame has arrived and the port is idle
    task drain();
        int n;
        n = 0;
        @(negedge core_clk);
        while ((exp_q.size() != 0 || tx_busy[0] !== 1'b0) && n < 30000) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 30000) stall();
        @(posedge core_clk);
    endtask
    // Each received frame is compared with the oldest expected one
    always @(posedge core_clk) begin
        if (rx_valid === 1'b1) begin
            compares++;
            if (exp_q.size() == 0 || rx_data !== exp_q[0]) begin
                miscompares++;
                $display("MISMATCH %0t unexpected frame %h", $time, rx_data);
            end
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end
    initial begin
        resetn = 1'b0;
        tx_data = 16'h0000;
        tx_valid = 2'h0;
        cd_check_mode = 2'h0;
        dr_check_mode = 2'h0;
        rs_mode = 2'h0;
        er_mode = 2'h0;
        er_sw = 2'h0;
        m_cs = 1'b1;
        m_dr = 1'b0;
        m_cd = 1'b1;
        baud_sel = 8'hcc;
        bit_cyc = 16'h0057;
        cyc(12);
        resetn <= 1'b1;
        cyc(2);
        chk(rs_out, 2'h3);
        chk(er_out, 2'h3);
        // Back to back; carrier on and data set off are ignored by default
        for (int i = 0; i < 3; i++) send(rnd());
        tx_valid <= 2'h0;
        drain();
        // Clear to send off: fill until refused, nothing may leave
        m_cs <= 1'b0;
        cyc(4);
        tx_data[7:0] <= rnd();
        tx_valid[0] <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            @(negedge core_clk);
            if (tx_ready[0] !== 1'b1) break;
            @(posedge core_clk);
            exp_q.push_back({1'b1, tx_data[7:0]});
            tx_data[7:0] <= rnd();
        end
        @(posedge core_clk);
        tx_valid <= 2'h0;
        chk(tx_blocked, 2'h1);
        chk(tx_busy, 2'h1);
        chk(sd_out, 2'h3);
        cyc(300);
        chk(tx_ready, 2'h2);
        m_cs <= 1'b1;
        drain();
        // Carrier check on port 0 only
        cd_check_mode[0] <= 1'b1;
        send(rnd());
        tx_valid <= 2'h0;
        cyc(300);
        chk(tx_blocked, 2'h1);
        m_cd <= 1'b0;
        drain();
        // Data set check on port 0 only
        dr_check_mode[0] <= 1'b1;
        send(rnd());
        tx_valid <= 2'h0;
        cyc(300);
        chk(tx_blocked, 2'h1);
        m_dr <= 1'b1;
        drain();
        // Request to send raised only around a transfer
        rs_mode[0] <= 1'b1;
        // This transfer also runs at 9600 bit/s, 1042 clocks a bit
        baud_sel[3:0] <= 4'h5;
        bit_cyc <= 16'h0412;
        cyc(3);
        chk(rs_out, 2'h2);
        send(rnd());
        tx_valid <= 2'h0;
        cyc(500);
        chk({rs_out[0], sd_out[0]}, 2'h3);
        drain();
        cyc(3);
        chk(rs_out, 2'h2);
        // Terminal ready under software, ports set apart
        er_mode <= 2'h3;
        er_sw <= 2'h1;
        cyc(2);
        chk(er_out, 2'h1);
        er_sw <= 2'h2;
        cyc(2);
        chk(er_out, 2'h2);
        // Second port sends on its own while the first stays idle
        tx_data[15:8] <= rnd();
        tx_valid[1] <= 1'b1;
        cyc(1);
        tx_valid[1] <= 1'b0;
        cyc(4);
        chk(sd_out, 2'h1);
        wrap_up();
    end
endmodule // test_serial_port_modem_handshake
`default_nettype wire
